//--- ece_pkg.sv
// Constants shared by the encoder command executor.
// Assumes an 8-bit serial register port and a single 200 MHz clock.
package ece_pkg;
    // ------------------------------------------------------------
    // Register addresses on the serial register port
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TFA = 8'h5b; // Target first address
    localparam logic [7:0] ADDR_BFI = 8'h5c; // Buffer first index
    localparam logic [7:0] ADDR_BLI = 8'h5d; // Buffer last index
    localparam logic [7:0] ADDR_TID = 8'h5e; // Target id byte
    localparam logic [7:0] ADDR_CFG = 8'h60; // Target config
    localparam logic [7:0] ADDR_TALLY = 8'h73; // Event tally
    localparam logic [7:0] ADDR_CMD = 8'h75; // Command register
    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_NONE = 8'h00;
    localparam logic [7:0] CMD_MT_RESYNC = 8'h05;
    localparam logic [7:0] CMD_MT_CHECK = 8'h06;
    localparam logic [7:0] CMD_WARM = 8'h07;
    localparam logic [7:0] CMD_PRE_APPLY = 8'h08;
    localparam logic [7:0] CMD_PRE_STORE = 8'h09;
    localparam logic [7:0] CMD_I2C = 8'h0a;
    localparam logic [7:0] CMD_TALLY = 8'h0b;
    localparam logic [7:0] CMD_SWITCH = 8'h0c;
    localparam logic [7:0] CMD_CKS_VER = 8'h0d;
    localparam logic [7:0] CMD_CKS_CALC = 8'h0e;
    localparam logic [7:0] CMD_PIN_HI = 8'h0f;
    localparam logic [7:0] CMD_PIN_LO = 8'h10;
    // ------------------------------------------------------------
    // Fields, codes and counts
    // ------------------------------------------------------------
    localparam int PF_LSB = 0; // Port function field
    localparam int PF_MSB = 2;
    localparam int PL_LSB = 6; // Protection field
    localparam int PL_MSB = 7;
    localparam logic [1:0] PROT_OPEN = 2'h0; // Open, transfer allowed
    localparam logic [1:0] PROT_LOCK_XFER = 2'h2; // Locked, transfer ok
    localparam logic [1:0] MAX_RETRY = 2'h3; // Further transfer attempts
    localparam logic [1:0] STEP_A = 2'h0; // Sequence step indices
    localparam logic [1:0] STEP_B = 2'h1;
    localparam logic [1:0] STEP_C = 2'h2;
    localparam logic [7:0] BYTE_RST = 8'h00; // Reset of byte registers
    localparam logic [2:0] PF_RST = 3'h0;
    localparam logic [1:0] PL_RST = 2'h0;
    // Jobs handed to the device's worker engines
    typedef enum logic [3:0] {
        job_none, job_mt_read, job_cfg_load, job_abs_redef, job_preset,
        job_off_store, job_cks_update, job_i2c, job_cfg_write,
        job_cks_verify, job_cks_recalc
    } ece_job_e;
endpackage : ece_pkg

//--- ece_cmd_exec.sv
// Command executor of a magnetic position encoder.
// Assumes the serial interface delivers register reads and writes as
// one-cycle strobes and that worker engines answer each job with a
// one-cycle done pulse.
// Notes on behaviour
// - Command code held while queued, cleared on start
// - Codes 06 check, 07 restart, 0a transfer
// - Resync never restarts output converter itself
// - Check compares read and counted multiturn values
// - Restart resets engines, reloads config, redefines
// - Preset apply alters offset, updates checksum
// - Preset store also writes offset to EEPROM
// - Transfer only at protection 0 or 2
// - Up to three retries after transfer error
// - Index, id byte and address steer transfer
// - Length is last minus first plus one
// - Switch swaps targets in, writes, restores
// - Checksum fault if checking on and differing
// - Targets take effect at restart, and during a switch write
// - Three-bit port function target, eight codes
// - Two-bit protection target, four codes
// - Verify sets fault; recompute refreshes checksums
// - Pin commands snapshot data pin, then drive
module ece_cmd_exec (
    input wire logic clock_i, // 200 MHz
    input wire logic rst_n_i, // Synchronous, active low
    input wire logic reg_wr_i, // Register write strobe
    input wire logic reg_rd_i, // Register read strobe
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o, // Valid cycle after read
    input wire logic job_done_i, // Worker finished
    input wire logic job_error_i, // Worker error, with done
    input wire logic [15:0] mt_value_i, // Read-in multiturn
    input wire logic [15:0] mt_count_i, // Counted multiturn
    input wire logic cyclic_check_disable_i, // 1 = no cyclic check
    input wire logic status_clear_i, // Clears both fault flags
    input wire logic multiturn_data_pin_i,
    output ece_pkg::ece_job_e job_code_o, // Job for workers
    output logic job_req_o, // Held until done
    output logic sm_reset_o, // One-cycle engine reset
    output logic [2:0] port_function_now_o,
    output logic [1:0] protection_level_now_o,
    output logic [7:0] i2c_target_id_byte_o,
    output logic [7:0] i2c_target_first_address_o,
    output logic [7:0] i2c_buffer_first_index_o,
    output logic [8:0] i2c_length_o, // Bytes to move
    output logic multiturn_mismatch_flag_o,
    output logic checksum_fault_flag_o,
    output logic multiturn_control_pin_o,
    output logic data_pin_snapshot_o,
    output logic busy_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {st_idle, st_step, st_wait} ece_state_e;

    ece_state_e st_reg, st_next; // Sequencer state
    logic [7:0] cmd_reg, cmd_next; // Queued command
    logic [7:0] cur_reg, cur_next; // Running command
    logic [1:0] step_reg, step_next; // Sequence step
    logic [1:0] retry_reg, retry_next; // Transfer retries used
    ece_pkg::ece_job_e job_reg, job_next;
    logic req_reg, req_next;
    logic srst_reg, srst_next;
    logic [2:0] pf_reg, pf_next, pfs_reg, pfs_next, pft_reg, pft_next;
    logic [1:0] pl_reg, pl_next, pls_reg, pls_next, plt_reg, plt_next;
    logic [7:0] tfa_reg, tfa_next, bfi_reg, bfi_next;
    logic [7:0] bli_reg, bli_next, tid_reg, tid_next;
    logic [7:0] tally_reg, tally_next, rd_reg, rd_next;
    logic [8:0] len_reg, len_next;
    logic mm_reg, mm_next, ck_reg, ck_next;
    logic pin_reg, pin_next, snap_reg, snap_next;
    logic busy_reg, busy_next; // Command running
    ece_pkg::ece_job_e seq_job; // Job of the current step
    logic wr_cmd; // Host writes the command register
    logic xfer_ok; // Protection permits transfers

    // Job list of each command; job_none ends the sequence
    function automatic ece_pkg::ece_job_e job_of(input logic [7:0] c,
                                                 input logic [1:0] s);
        job_of = ece_pkg::job_none;
        case (c)
            // Resync only reads; no converter restart.
            ece_pkg::CMD_MT_RESYNC,
            ece_pkg::CMD_MT_CHECK: begin
                if (s == ece_pkg::STEP_A) job_of = ece_pkg::job_mt_read;
            end
            ece_pkg::CMD_WARM: begin
                if (s == ece_pkg::STEP_A) job_of = ece_pkg::job_cfg_load;
                if (s == ece_pkg::STEP_B) job_of = ece_pkg::job_abs_redef;
            end
            ece_pkg::CMD_PRE_APPLY: begin
                if (s == ece_pkg::STEP_A) job_of = ece_pkg::job_preset;
                if (s == ece_pkg::STEP_B) job_of = ece_pkg::job_cks_update;
            end
            ece_pkg::CMD_PRE_STORE: begin
                if (s == ece_pkg::STEP_A) job_of = ece_pkg::job_preset;
                if (s == ece_pkg::STEP_B) job_of = ece_pkg::job_off_store;
                if (s == ece_pkg::STEP_C) job_of = ece_pkg::job_cks_update;
            end
            ece_pkg::CMD_I2C: begin
                if (s == ece_pkg::STEP_A) job_of = ece_pkg::job_i2c;
            end
            ece_pkg::CMD_SWITCH: begin
                if (s == ece_pkg::STEP_A) job_of = ece_pkg::job_cfg_write;
            end
            ece_pkg::CMD_CKS_VER: begin
                if (s == ece_pkg::STEP_A) job_of = ece_pkg::job_cks_verify;
            end
            ece_pkg::CMD_CKS_CALC: begin
                if (s == ece_pkg::STEP_A) job_of = ece_pkg::job_cks_recalc;
            end
            default: job_of = ece_pkg::job_none;
        endcase
    endfunction : job_of

    assign seq_job = job_of(cur_reg, step_reg);
    assign wr_cmd = reg_wr_i && (reg_addr_i == ece_pkg::ADDR_CMD);
    assign xfer_ok = (pl_reg == ece_pkg::PROT_OPEN) ||
                     (pl_reg == ece_pkg::PROT_LOCK_XFER);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Register port, sequencer and status in one place, since the
    // sequencer also writes registers (tally, current port function and protection, flags).
    always_comb begin
        st_next = st_reg;
        cmd_next = cmd_reg;
        cur_next = cur_reg;
        step_next = step_reg;
        retry_next = retry_reg;
        job_next = job_reg;
        req_next = req_reg;
        srst_next = 1'b0;
        pf_next = pf_reg;
        pl_next = pl_reg;
        pfs_next = pfs_reg;
        pls_next = pls_reg;
        pft_next = pft_reg;
        plt_next = plt_reg;
        tfa_next = tfa_reg;
        bfi_next = bfi_reg;
        bli_next = bli_reg;
        tid_next = tid_reg;
        tally_next = tally_reg;
        len_next = len_reg;
        mm_next = mm_reg;
        ck_next = ck_reg;
        pin_next = pin_reg;
        snap_next = snap_reg;
        rd_next = rd_reg;
        // Flags: clear first so a same-cycle set below wins
        if (status_clear_i) begin
            mm_next = 1'b0;
            ck_next = 1'b0;
        end
        // Host writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                ece_pkg::ADDR_CMD: cmd_next = reg_wdata_i;
                ece_pkg::ADDR_TFA: tfa_next = reg_wdata_i;
                ece_pkg::ADDR_BFI: bfi_next = reg_wdata_i;
                ece_pkg::ADDR_BLI: bli_next = reg_wdata_i;
                ece_pkg::ADDR_TID: tid_next = reg_wdata_i;
                ece_pkg::ADDR_TALLY: tally_next = reg_wdata_i;
                ece_pkg::ADDR_CFG: begin
                    pft_next = reg_wdata_i[ece_pkg::PF_MSB:ece_pkg::PF_LSB];
                    plt_next = reg_wdata_i[ece_pkg::PL_MSB:ece_pkg::PL_LSB];
                end
                default: ; // Unmapped writes are ignored
            endcase
        end
        // Host reads; command register is write-only
        if (reg_rd_i) begin
            case (reg_addr_i)
                ece_pkg::ADDR_TFA: rd_next = tfa_reg;
                ece_pkg::ADDR_BFI: rd_next = bfi_reg;
                ece_pkg::ADDR_BLI: rd_next = bli_reg;
                ece_pkg::ADDR_TID: rd_next = tid_reg;
                ece_pkg::ADDR_TALLY: rd_next = tally_reg;
                ece_pkg::ADDR_CFG: begin
                    rd_next = ece_pkg::BYTE_RST;
                    rd_next[ece_pkg::PF_MSB:ece_pkg::PF_LSB] = pft_reg;
                    rd_next[ece_pkg::PL_MSB:ece_pkg::PL_LSB] = plt_reg;
                end
                default: rd_next = ece_pkg::BYTE_RST;
            endcase
        end
        case (st_reg)
            // Take the queued command only when nothing runs.
            st_idle: begin
                if (cmd_reg != ece_pkg::CMD_NONE) begin
                    cur_next = cmd_reg;
                    if (!wr_cmd) cmd_next = ece_pkg::CMD_NONE;
                    step_next = ece_pkg::STEP_A;
                    retry_next = 2'h0;
                    st_next = st_step;
                end
            end
            st_step: begin
                if (seq_job == ece_pkg::job_none) begin
                    // Single-cycle commands run here
                    if (step_reg == ece_pkg::STEP_A) begin
                        if (cur_reg == ece_pkg::CMD_TALLY && !(reg_wr_i &&
                            reg_addr_i == ece_pkg::ADDR_TALLY))
                            tally_next = tally_reg + 8'h01;
                        if (cur_reg == ece_pkg::CMD_PIN_HI ||
                            cur_reg == ece_pkg::CMD_PIN_LO) begin
                            snap_next = multiturn_data_pin_i;
                            pin_next = (cur_reg == ece_pkg::CMD_PIN_HI);
                        end
                    end
                    st_next = st_idle;
                end else if (seq_job == ece_pkg::job_i2c && !xfer_ok) begin
                    st_next = st_idle; // Refused silently.
                end else begin
                    if (seq_job == ece_pkg::job_cfg_load)
                        srst_next = 1'b1;
                    if (seq_job == ece_pkg::job_i2c)
                        len_next = {1'b0, bli_reg} - {1'b0, bfi_reg}
                                   + 9'h001;
                    if (seq_job == ece_pkg::job_cfg_write) begin
                        pfs_next = pf_reg;
                        pls_next = pl_reg;
                        pf_next = pft_reg;
                        pl_next = plt_reg;
                    end
                    job_next = seq_job;
                    req_next = 1'b1;
                    st_next = st_wait;
                end
            end
            st_wait: begin
                if (job_done_i) begin
                    req_next = 1'b0;
                    job_next = ece_pkg::job_none;
                    st_next = st_step;
                    step_next = step_reg + 2'h1;
                    case (job_reg)
                        ece_pkg::job_mt_read: begin
                            if (cur_reg == ece_pkg::CMD_MT_CHECK &&
                                mt_value_i != mt_count_i)
                                mm_next = 1'b1;
                        end
                        ece_pkg::job_i2c: begin
                            if (job_error_i && retry_reg != ece_pkg::MAX_RETRY)
                            begin
                                retry_next = retry_reg + 2'h1;
                                step_next = step_reg;
                            end
                        end
                        ece_pkg::job_cfg_load: begin
                            pf_next = pft_reg;
                            pl_next = plt_reg;
                            retry_next = 2'h0;
                        end
                        ece_pkg::job_cfg_write: begin
                            pf_next = pfs_reg;
                            pl_next = pls_reg;
                            if (!cyclic_check_disable_i &&
                                (pfs_reg != pft_reg || pls_reg != plt_reg))
                                ck_next = 1'b1;
                        end
                        ece_pkg::job_cks_verify: begin
                            if (job_error_i) ck_next = 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
            default: st_next = st_idle;
        endcase
        // Registered copy of the state decode, so busy has no glitches
        busy_next = (st_next != st_idle);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Warm restart does not clear host registers, only engines
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_reg <= st_idle;
            cmd_reg <= ece_pkg::CMD_NONE;
            cur_reg <= ece_pkg::CMD_NONE;
            step_reg <= ece_pkg::STEP_A;
            retry_reg <= 2'h0;
            job_reg <= ece_pkg::job_none;
            req_reg <= 1'b0;
            srst_reg <= 1'b0;
            pf_reg <= ece_pkg::PF_RST;
            pl_reg <= ece_pkg::PL_RST;
            pfs_reg <= ece_pkg::PF_RST;
            pls_reg <= ece_pkg::PL_RST;
            pft_reg <= ece_pkg::PF_RST;
            plt_reg <= ece_pkg::PL_RST;
            tfa_reg <= ece_pkg::BYTE_RST;
            bfi_reg <= ece_pkg::BYTE_RST;
            bli_reg <= ece_pkg::BYTE_RST;
            tid_reg <= ece_pkg::BYTE_RST;
            tally_reg <= ece_pkg::BYTE_RST;
            len_reg <= 9'h000;
            mm_reg <= 1'b0;
            ck_reg <= 1'b0;
            pin_reg <= 1'b0;
            snap_reg <= 1'b0;
            rd_reg <= ece_pkg::BYTE_RST;
            busy_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cmd_reg <= cmd_next;
            cur_reg <= cur_next;
            step_reg <= step_next;
            retry_reg <= retry_next;
            job_reg <= job_next;
            req_reg <= req_next;
            srst_reg <= srst_next;
            pf_reg <= pf_next;
            pl_reg <= pl_next;
            pfs_reg <= pfs_next;
            pls_reg <= pls_next;
            pft_reg <= pft_next;
            plt_reg <= plt_next;
            tfa_reg <= tfa_next;
            bfi_reg <= bfi_next;
            bli_reg <= bli_next;
            tid_reg <= tid_next;
            tally_reg <= tally_next;
            len_reg <= len_next;
            mm_reg <= mm_next;
            ck_reg <= ck_next;
            pin_reg <= pin_next;
            snap_reg <= snap_next;
            rd_reg <= rd_next;
            busy_reg <= busy_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign reg_rdata_o = rd_reg;
    assign job_code_o = job_reg;
    assign job_req_o = req_reg;
    assign sm_reset_o = srst_reg;
    assign port_function_now_o = pf_reg;
    assign protection_level_now_o = pl_reg;
    assign i2c_target_id_byte_o = tid_reg;
    assign i2c_target_first_address_o = tfa_reg;
    assign i2c_buffer_first_index_o = bfi_reg;
    assign i2c_length_o = len_reg;
    assign multiturn_mismatch_flag_o = mm_reg;
    assign checksum_fault_flag_o = ck_reg;
    assign multiturn_control_pin_o = pin_reg;
    assign data_pin_snapshot_o = snap_reg;
    assign busy_o = busy_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_cmd_clear;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_reg == st_idle && cmd_reg != ece_pkg::CMD_NONE && !wr_cmd)
        |=> (cmd_reg == ece_pkg::CMD_NONE && st_reg == st_step);
    endproperty
    a_cmd_clear: assert property (p_cmd_clear)
        else $error("command register not cleared on start");

    property p_no_redef;
        @(posedge clock_i) disable iff (!rst_n_i)
        (cur_reg == ece_pkg::CMD_MT_RESYNC && req_reg)
        |-> (job_reg == ece_pkg::job_mt_read);
    endproperty
    a_no_redef: assert property (p_no_redef)
        else $error("resync issued a job other than read");

    property p_mismatch;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_reg == st_wait && job_done_i && cur_reg == ece_pkg::CMD_MT_CHECK
         && mt_value_i != mt_count_i) |=> multiturn_mismatch_flag_o;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("multiturn mismatch not flagged");

    property p_xfer_block;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_reg == st_step && seq_job == ece_pkg::job_i2c && !xfer_ok)
        |=> (st_reg == st_idle && !job_req_o);
    endproperty
    a_xfer_block: assert property (p_xfer_block)
        else $error("transfer started under locked protection");

    property p_retry_end;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_reg == st_wait && job_done_i && job_reg == ece_pkg::job_i2c &&
         job_error_i && retry_reg == ece_pkg::MAX_RETRY)
        |=> ##1 (st_reg == st_idle);
    endproperty
    a_retry_end: assert property (p_retry_end)
        else $error("transfer retried beyond limit");

    property p_len;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_reg == st_step && seq_job == ece_pkg::job_i2c && xfer_ok)
        |=> (i2c_length_o == {1'b0, $past(bli_reg)} -
             {1'b0, $past(bfi_reg)} + 9'h001) && job_req_o;
    endproperty
    a_len: assert property (p_len)
        else $error("transfer length wrong");

    property p_pin;
        @(posedge clock_i) disable iff (!rst_n_i)
        (st_reg == st_step && step_reg == ece_pkg::STEP_A &&
         cur_reg == ece_pkg::CMD_PIN_HI)
        |=> (multiturn_control_pin_o &&
             data_pin_snapshot_o == $past(multiturn_data_pin_i));
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin drive or snapshot wrong");

    property p_switch_hold;
        @(posedge clock_i) disable iff (!rst_n_i)
        (req_reg && job_reg == ece_pkg::job_cfg_write && job_done_i)
        |=> (port_function_now_o == $past(pfs_reg, 1) &&
             protection_level_now_o == $past(pls_reg, 1));
    endproperty
    a_switch_hold: assert property (p_switch_hold)
        else $error("original config not restored after switch");

    property p_one_job;
        @(posedge clock_i) disable iff (!rst_n_i)
        job_req_o |-> (st_reg == st_wait);
    endproperty
    a_one_job: assert property (p_one_job)
        else $error("job requested outside wait state");
endmodule : ece_cmd_exec

//--- ece_worker_model.sv
// Worker engine model: answers each job of the executor with one done
// pulse. Assumes a job request is held until the cycle after done.
module ece_worker_model (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic job_req_i,
    input wire logic [7:0] lat_i, // Cycles from request to done, 1 or more
    input wire logic fail_i, // Report every job as failed
    output logic done_o,
    output logic error_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_reg; // Cycles since the request rose
    logic [7:0] cnt_next;
    // ------------------------------------------------------------
    // Request timer
    // ------------------------------------------------------------
    // Saturates, so a slow executor never sees a second done pulse
    always_comb begin
        cnt_next = cnt_reg;
        if (!job_req_i) begin
            cnt_next = 8'h00;
        end else if (cnt_reg != 8'hff) begin
            cnt_next = cnt_reg + 8'h01;
        end
    end
    always_ff @(posedge clock_i) begin
        cnt_reg <= rst_n_i ? cnt_next : 8'h00;
    end
    assign done_o = job_req_i && (cnt_reg == lat_i); // Never same cycle
    assign error_o = done_o && fail_i; // Qualifies done only
endmodule : ece_worker_model

//--- tb_ece_cmd_exec.sv
// Self-checking bench for the command executor.
// Assumes the worker model answers every job that the executor issues.
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb_ece_cmd_exec;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, fail = 0, ccd = 0, sclr = 0;
    logic dpin = 0, done, err, req, smr, q = 0, mm, cf, pin, snap, busy;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdat, lat = 8'h03, tid, tfa, bfi;
    logic [15:0] mtv = 16'h0001;
    logic [2:0] pf;
    logic [1:0] pl;
    logic [8:0] len;
    ece_pkg::ece_job_e job;
    int failures = 0, n_compared = 0, rises = 0, resets = 0;
    always #2.5 clk = ~clk;
    logic [23:0] seq = 24'h000000; // Codes of the last six jobs
    localparam logic [23:0] PRE_SEQ = {ece_pkg::job_cks_recalc,
        ece_pkg::job_preset, ece_pkg::job_cks_update, ece_pkg::job_preset,
        ece_pkg::job_off_store, ece_pkg::job_cks_update};
    // Job and engine reset pulses, counted where outputs are settled
    always @(negedge clk) begin
        if (req === 1'b1 && q === 1'b0) begin
            rises++;
            seq = {seq[19:0], job};
        end
        resets += (smr === 1'b1);
        q = req;
    end
    ece_cmd_exec ece_cmd_exec_i (.clock_i(clk), .rst_n_i(rst_n),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_rdata_o(rdat), .job_done_i(done), .job_error_i(err),
        .mt_value_i(mtv), .mt_count_i(16'h0001), .cyclic_check_disable_i(ccd),
        .status_clear_i(sclr), .multiturn_data_pin_i(dpin), .job_code_o(job),
        .job_req_o(req), .sm_reset_o(smr), .port_function_now_o(pf),
        .protection_level_now_o(pl), .i2c_target_id_byte_o(tid),
        .i2c_target_first_address_o(tfa), .i2c_buffer_first_index_o(bfi),
        .i2c_length_o(len), .multiturn_mismatch_flag_o(mm),
        .checksum_fault_flag_o(cf), .multiturn_control_pin_o(pin),
        .data_pin_snapshot_o(snap), .busy_o(busy));
    ece_worker_model ece_worker_model_i (.clock_i(clk), .rst_n_i(rst_n),
        .job_req_i(req), .lat_i(lat), .fail_i(fail), .done_o(done),
        .error_o(err));
    // ------------------------------------------------------------
    // Register port tasks, driven on the falling edge
    // ------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) {wr, addr, wd} = {1'b1, a, d};
        @(negedge clk) wr = 0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk) {rd, addr} = {1'b1, a};
        @(negedge clk) rd = 0;
        `CHK(rdat, e)
    endtask : rd_reg
    // Issue a command and wait, bounded, until the executor is idle
    task automatic run(input logic [7:0] c);
        int n;
        wr_reg(ece_pkg::ADDR_CMD, c);
        repeat (3) @(negedge clk);
        for (n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge clk);
        `CHK(busy, 1'b0)
    endtask : run
    task automatic print_verdict();
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    // Watchdog: the whole sequence needs well under 10 us
    initial begin
        #200us failures++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1;
        wr_reg(ece_pkg::ADDR_TALLY, 8'hff);
        run(ece_pkg::CMD_TALLY);
        rd_reg(ece_pkg::ADDR_TALLY, 8'h00);
        rd_reg(ece_pkg::ADDR_CMD, 8'h00);
        wr_reg(ece_pkg::ADDR_BFI, 8'h10);
        wr_reg(ece_pkg::ADDR_BLI, 8'h10);
        wr_reg(ece_pkg::ADDR_TID, 8'ha1);
        wr_reg(ece_pkg::ADDR_TFA, 8'h20);
        fail = 1; // Every transfer attempt fails
        run(ece_pkg::CMD_I2C);
        `CHK(rises, 4)
        `CHK(len, 9'h001)
        `CHK({tid, tfa, bfi}, 24'ha12010)
        fail = 0;
        wr_reg(ece_pkg::ADDR_BFI, 8'h00);
        wr_reg(ece_pkg::ADDR_BLI, 8'hff);
        run(ece_pkg::CMD_I2C);
        `CHK(len, 9'h100)
        mtv = 16'h0002; // Read-in value differs from counted one
        run(ece_pkg::CMD_MT_CHECK);
        `CHK(mm, 1'b1)
        @(negedge clk) sclr = 1;
        @(negedge clk) sclr = 0;
        `CHK({mm, cf}, 2'b00)
        run(ece_pkg::CMD_MT_RESYNC); // Values still differ
        `CHK({mm, seq[3:0]}, {1'b0, ece_pkg::job_mt_read})
        ccd = 1; // Cyclic check off: switch raises no fault
        wr_reg(ece_pkg::ADDR_CFG, 8'h43);
        run(ece_pkg::CMD_SWITCH); // Protection still open.
        `CHK({pl, pf, cf}, 6'h00)
        ccd = 0;
        lat = 8'h14; // Slow worker, so the swap can be seen
        wr_reg(ece_pkg::ADDR_CFG, 8'h43);
        wr_reg(ece_pkg::ADDR_CMD, ece_pkg::CMD_SWITCH);
        repeat (8) @(negedge clk);
        `CHK({pl, pf}, 5'h0b)
        run(ece_pkg::CMD_NONE);
        `CHK({pl, pf, cf}, 6'h01)
        rd_reg(ece_pkg::ADDR_CFG, 8'h43);
        run(ece_pkg::CMD_WARM);
        `CHK(resets, 1)
        `CHK({pl, pf}, 5'h0b)
        repeat (64) @(negedge clk); // Quiet gap, scaled down.
        rises = 0;
        run(ece_pkg::CMD_I2C);
        `CHK(rises, 0)
        dpin = 0; // No external multiturn here.
        run(ece_pkg::CMD_PIN_HI);
        `CHK({pin, snap}, 2'b10)
        dpin = 1;
        run(ece_pkg::CMD_PIN_LO);
        `CHK({pin, snap}, 2'b01)
        @(negedge clk) sclr = 1;
        @(negedge clk) sclr = 0;
        fail = 1; // Verify reports a mismatch
        run(ece_pkg::CMD_CKS_VER);
        `CHK(cf, 1'b1)
        fail = 0;
        run(ece_pkg::CMD_CKS_CALC);
        run(ece_pkg::CMD_PRE_APPLY);
        run(ece_pkg::CMD_PRE_STORE); // Offsets after switch.
        `CHK(seq, PRE_SEQ)
        print_verdict();
    end
endmodule : tb_ece_cmd_exec
